/* bench/ccr_regs_tb.sv */
// self-checking testbench for the clock and sysref control register bank
`timescale 1ns/100ps
module ccr_regs_tb;
    localparam logic [7:0] A_CTL0 = {ccr_pkg::IDX_CTL0, 2'b00};
    localparam logic [7:0] A_CTL1 = {ccr_pkg::IDX_CTL1, 2'b00};
    localparam logic [7:0] A_CTL2 = {ccr_pkg::IDX_CTL2, 2'b00};
    localparam logic [7:0] A_POS  = {ccr_pkg::IDX_POS, 2'b00};
    localparam logic [7:0] A_FSA  = {ccr_pkg::IDX_FSA, 2'b00};
    localparam logic [7:0] A_TSC  = {ccr_pkg::IDX_TSC, 2'b00};
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sysref_pin = 1'b0;
    logic [23:0] taps_coarse_pin = 24'h00_0ff0;
    logic [23:0] taps_fine_pin = 24'h0f_0000;
    logic [11:0] sample_in = 12'h000;
    logic        sample_in_valid = 1'b0;
    logic [11:0] sample_out;
    logic        sample_out_valid;
    logic        sysref_aligned;
    logic        dev_pecl;
    logic        sr_pecl;
    logic        gain_high;
    logic        noise_sup;
    logic [1:0]  clk_del;
    logic [3:0]  dly_sel;
    logic        win_fine;
    logic        auto_cal;
    logic [15:0] fsa;
    int          n_errors = 0;
    int          checks_done = 0;

    ccr_regs ccr_regs_i (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sysref_pin(sysref_pin), .taps_coarse_pin(taps_coarse_pin),
        .taps_fine_pin(taps_fine_pin),
        .sample_in(sample_in), .sample_in_valid(sample_in_valid),
        .sample_out(sample_out), .sample_out_valid(sample_out_valid),
        .sysref_aligned(sysref_aligned), .device_clock_dc_pecl_en(dev_pecl),
        .sysref_dc_pecl_en(sr_pecl), .clock_converter_gain_high(gain_high),
        .analog_supply_noise_suppress(noise_sup), .sample_clock_delay_sel(clk_del),
        .sysref_delay_select(dly_sel), .sysref_window_fine(win_fine),
        .sysref_auto_cal(auto_cal), .fullscale_range_chan_a(fsa)
    );

    always #50 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_pin(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle, held until ack is sampled, then one idle cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                           input logic [3:0] sel, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= wd;
        do begin
            @(posedge clk_sys);
            n++;
            if (n > 20) begin
                n_errors++;
                $display("[FAIL] wb_ack_o expected 1 seen 0");
                tally_and_finish();
            end
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] rd;
        wb_xfer(1'b1, adr, wd, 4'hf, rd);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_xfer(1'b0, adr, 32'h0000_0000, 4'hf, rd);
        cmp_reg(what, exp, rd);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic t_reset_values();
        settle(1);
        cmp_pin("gain_high", 16'h0001, {15'h0000, gain_high});
        cmp_pin("noise_sup", 16'h0000, {15'h0000, noise_sup});
        cmp_pin("clk_del", 16'h0001, {14'h0000, clk_del});
        cmp_pin("fsa", 16'ha000, fsa);
        rd_chk("ctl1", A_CTL1, 32'h0000_0000);
        rd_chk("ctl2", A_CTL2, 32'h0000_0011);
        rd_chk("pos", A_POS, 32'h0000_0000);
        rd_chk("fsa", A_FSA, 32'h0000_a000);
        rd_chk("unmapped", 8'h40, 32'h0000_0000);
    endtask

    task automatic t_receivers();
        wr(A_CTL1, 32'h0000_00f4);
        settle(1);
        cmp_pin("dev_pecl", 16'h0001, {15'h0000, dev_pecl});
        cmp_pin("sr_pecl", 16'h0000, {15'h0000, sr_pecl});
        rd_chk("ctl1", A_CTL1, 32'h0000_00f4);
        wr(A_CTL1, 32'h0000_0002);
        settle(1);
        cmp_pin("dev_pecl", 16'h0000, {15'h0000, dev_pecl});
        cmp_pin("sr_pecl", 16'h0001, {15'h0000, sr_pecl});
        wr(A_CTL1, 32'h0000_0000);
    endtask

    task automatic t_clock_two();
        logic [31:0] rd;
        wr(A_CTL2, 32'h0000_00ee);
        settle(1);
        cmp_pin("gain_high", 16'h0000, {15'h0000, gain_high});
        cmp_pin("noise_sup", 16'h0001, {15'h0000, noise_sup});
        cmp_pin("clk_del", 16'h0002, {14'h0000, clk_del});
        rd_chk("ctl2", A_CTL2, 32'h0000_00ee);
        wr(A_FSA, 32'hffff_1234);
        rd_chk("fsa", A_FSA, 32'h0000_1234);
        wb_xfer(1'b1, A_FSA, 32'h0000_5678, 4'h1, rd);
        rd_chk("fsa low lane", A_FSA, 32'h0000_1278);
        wr(A_POS, 32'h0012_3456);
        rd_chk("pos", A_POS, 32'h0000_0000);
    endtask

    // sample lsb follows the aligned sysref only with all three enables
    task automatic t_stamp(input logic [7:0] c1, input logic [7:0] tsc, input logic [11:0] exp);
        wr(A_CTL1, {24'h00_0000, c1});
        wr(A_TSC, {24'h00_0000, tsc});
        settle(5);
        cmp_pin("sample_out", {4'h0, exp}, {4'h0, sample_out});
        cmp_pin("sample_valid", 16'h0001, {15'h0000, sample_out_valid});
    endtask

    task automatic t_polarity();
        @(posedge clk_sys);
        sysref_pin <= 1'b1;
        sample_in <= 12'h0a4;
        sample_in_valid <= 1'b1;
        settle(5);
        cmp_pin("aligned", 16'h0001, {15'h0000, sysref_aligned});
        t_stamp(8'h08, 8'h03, 12'h0a5);
        t_stamp(8'h08, 8'h01, 12'h0a4);
        t_stamp(8'h00, 8'h03, 12'h0a4);
        @(posedge clk_sys);
        sample_in <= 12'h0a5;
        t_stamp(8'h09, 8'h03, 12'h0a4);
        cmp_pin("aligned", 16'h0000, {15'h0000, sysref_aligned});
        wr(A_CTL1, 32'h0000_0000);
        @(posedge clk_sys);
        sysref_pin <= 1'b0;
        sample_in_valid <= 1'b0;
        settle(5);
        cmp_pin("sample_valid", 16'h0000, {15'h0000, sample_out_valid});
    endtask

    task automatic pulse_sysref();
        @(posedge clk_sys);
        sysref_pin <= 1'b1;
        settle(8);
        @(posedge clk_sys);
        sysref_pin <= 1'b0;
        settle(8);
    endtask

    task automatic t_position();
        wr(A_CTL0, 32'h0000_0060);
        settle(1);
        cmp_pin("auto_cal", 16'h0001, {15'h0000, auto_cal});
        pulse_sysref();
        rd_chk("pos", A_POS, 32'h0000_0ff0);
        wr(A_CTL0, 32'h0000_00f5);
        settle(2);
        cmp_pin("win_fine", 16'h0001, {15'h0000, win_fine});
        cmp_pin("dly_sel", 16'h0005, {12'h000, dly_sel});
        cmp_pin("auto_cal", 16'h0000, {15'h0000, auto_cal});
        rd_chk("ctl0", A_CTL0, 32'h0000_00f5);
        pulse_sysref();
        rd_chk("pos", A_POS, 32'h000f_0000);
        wr(A_CTL0, 32'h0000_0060);
        settle(1);
        cmp_pin("auto_cal", 16'h0001, {15'h0000, auto_cal});
    endtask

    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset_values();
        t_receivers();
        t_clock_two();
        t_polarity();
        t_position();
        tally_and_finish();
    end
endmodule

/* design/ccr_pkg.sv */
// constants for the clock and sysref control register bank
// Functional notes
// (R1) timestamp bit and timestamp enable both set put sysref on sample lsb
// (R2) sysref timestamp only inserted when the down-converter is bypassed (decimation one)
// (R3) polarity invert bit 0 set makes alignment use the inverted sysref
// (R4) bit 2 of clock control one selects dc-coupled pecl device clock receiver
// (R5) bit 1 of clock control one selects dc-coupled pecl sysref receiver
// (R6) bit 4 of clock control two selects high converter gain, one after reset
// (R7) bit 2 of clock control two enables supply noise suppression, zero after reset
// (R8) two-bit sample clock delay field is one-hot, resets to binary 01
// (R9) sysref position is a 24-bit read-only word, undefined until first capture; here it resets to zero and reads zero until then
// (R10) software picks delay select from position window, zero for automatic calibration
// (R11) window fine bit makes position and delay select steps smaller
// (R12) reserved bits reset to zero, keep written values, have no effect
package ccr_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTL0 = 6'h29;
    localparam logic [5:0] IDX_CTL1 = 6'h2a;
    localparam logic [5:0] IDX_CTL2 = 6'h2b;
    localparam logic [5:0] IDX_POS  = 6'h2c;
    localparam logic [5:0] IDX_FSA  = 6'h30;
    localparam logic [5:0] IDX_TSC  = 6'h3f;
    localparam int         ADR_LSB  = 2;
    // reset values
    localparam logic [7:0]  RST_CTL0 = 8'h00;
    localparam logic [7:0]  RST_CTL1 = 8'h00;
    localparam logic [7:0]  RST_CTL2 = 8'h11;
    localparam logic [23:0] RST_POS  = 24'h00_0000;
    localparam logic [15:0] RST_FSA  = 16'ha000;
    localparam logic [7:0]  RST_TSC  = 8'h00;
    // clock control zero fields
    localparam int CTL0_SEL_LSB  = 0;
    localparam int CTL0_SEL_W    = 4;
    localparam int CTL0_FINE     = 4;
    localparam int CTL0_RECV     = 5;
    localparam int CTL0_PROC     = 6;
    // clock control one fields
    localparam int CTL1_INVERT   = 0;
    localparam int CTL1_SR_PECL  = 1;
    localparam int CTL1_DEV_PECL = 2;
    localparam int CTL1_TS_SR    = 3;
    // clock control two fields
    localparam int CTL2_DEL_LSB  = 0;
    localparam int CTL2_NOISE    = 2;
    localparam int CTL2_GAIN     = 4;
    // timestamp control fields
    localparam int TSC_TS_EN     = 0;
    localparam int TSC_BYPASS    = 1;
    // widths
    localparam int POS_W         = 24;
    localparam int SAMPLE_W      = 12;
endpackage

/* design/ccr_pos_capture.sv */
// sysref edge position capture from the delay-line taps
`timescale 1ns/100ps
module ccr_pos_capture #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // control
    input  wire logic         arm,
    input  wire logic         fine,
    input  wire logic         sysref,
    // tap snapshots, already synchronised
    input  wire logic [W-1:0] taps_coarse,
    input  wire logic [W-1:0] taps_fine,
    // result
    output logic      [W-1:0] position,
    output logic              captured
);
    logic         sysref_prev;
    logic         next_sysref_prev;
    logic [W-1:0] next_position;
    logic         next_captured;

    always_comb begin
        next_sysref_prev = sysref;
        next_position    = position;
        next_captured    = 1'b0;
        if (arm && sysref && !sysref_prev) begin
            next_position = fine ? taps_fine : taps_coarse; // R11
            next_captured = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sysref_prev <= 1'b0;
            position    <= '0;
            captured    <= 1'b0;
        end else begin
            sysref_prev <= next_sysref_prev;
            position    <= next_position; // R9
            captured    <= next_captured;
        end
    end
endmodule

/* design/ccr_regs.sv */
// clock and sysref control register bank with wishbone slave
`timescale 1ns/100ps
module ccr_regs #(
    parameter int SW = ccr_pkg::SAMPLE_W,
    parameter int PW = ccr_pkg::POS_W
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst_n,
    // wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic      [31:0]   wb_dat_o,
    output logic               wb_ack_o,
    // sysref pin and delay-line taps, asynchronous
    input  wire logic          sysref_pin,
    input  wire logic [PW-1:0] taps_coarse_pin,
    input  wire logic [PW-1:0] taps_fine_pin,
    // sample stream, same clock
    input  wire logic [SW-1:0] sample_in,
    input  wire logic          sample_in_valid,
    output logic      [SW-1:0] sample_out,
    output logic               sample_out_valid,
    // analog front-end controls
    output logic               sysref_aligned,
    output logic               device_clock_dc_pecl_en,
    output logic               sysref_dc_pecl_en,
    output logic               clock_converter_gain_high,
    output logic               analog_supply_noise_suppress,
    output logic      [1:0]    sample_clock_delay_sel,
    output logic      [3:0]    sysref_delay_select,
    output logic               sysref_window_fine,
    output logic               sysref_auto_cal,
    output logic      [15:0]   fullscale_range_chan_a
);
    // registers
    logic [7:0]    clock_control_zero;
    logic [7:0]    clock_control_one;
    logic [7:0]    clock_control_two;
    logic [15:0]   fullscale_range;
    logic [7:0]    timestamp_control;
    logic [7:0]    next_ctl0;
    logic [7:0]    next_ctl1;
    logic [7:0]    next_ctl2;
    logic [15:0]   next_fsa;
    logic [7:0]    next_tsc;
    // bus
    logic          next_ack;
    logic [31:0]   next_dat;
    logic          bus_req;
    logic          bus_wr;
    logic [5:0]    idx;
    // sysref and sample path
    logic          sysref_sync;
    logic          next_sysref_aligned;
    logic [SW-1:0] next_sample_out;
    logic          next_sample_valid;
    logic          ts_active;
    logic [PW-1:0] taps_coarse;
    logic [PW-1:0] taps_fine;
    logic [PW-1:0] sysref_edge_position;
    logic          pos_captured;

    ccr_sync #(.W(1)) u_sync_sysref (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     (sysref_pin),
        .dout    (sysref_sync)
    );

    ccr_sync #(.W(2*PW)) u_sync_taps (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .din     ({taps_fine_pin, taps_coarse_pin}),
        .dout    ({taps_fine, taps_coarse})
    );

    ccr_pos_capture #(.W(PW)) u_pos (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .arm         (clock_control_zero[ccr_pkg::CTL0_PROC]
                      & clock_control_zero[ccr_pkg::CTL0_RECV]),
        .fine        (clock_control_zero[ccr_pkg::CTL0_FINE]),
        .sysref      (sysref_aligned),
        .taps_coarse (taps_coarse),
        .taps_fine   (taps_fine),
        .position    (sysref_edge_position),
        .captured    (pos_captured)
    );

    // byte-lane merge for registers up to 16 bits
    function automatic logic [15:0] merge16(input logic [15:0] cur,
                                            input logic [31:0] wd,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = cur;
        if (sel[0]) r[7:0]  = wd[7:0];
        if (sel[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    assign idx     = wb_adr_i[7:ccr_pkg::ADR_LSB];
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr  = bus_req && wb_we_i;

    // register writes; reserved bits are stored like any other
    always_comb begin
        next_ctl0 = clock_control_zero;
        next_ctl1 = clock_control_one;
        next_ctl2 = clock_control_two;
        next_fsa  = fullscale_range;
        next_tsc  = timestamp_control;
        if (bus_wr) begin
            unique case (idx)
                ccr_pkg::IDX_CTL0: next_ctl0 = 8'(merge16({8'h00, clock_control_zero},
                                                          wb_dat_i, wb_sel_i));
                ccr_pkg::IDX_CTL1: next_ctl1 = 8'(merge16({8'h00, clock_control_one},
                                                          wb_dat_i, wb_sel_i)); // R12
                ccr_pkg::IDX_CTL2: next_ctl2 = 8'(merge16({8'h00, clock_control_two},
                                                          wb_dat_i, wb_sel_i)); // R12
                ccr_pkg::IDX_FSA:  next_fsa  = merge16(fullscale_range, wb_dat_i, wb_sel_i);
                ccr_pkg::IDX_TSC:  next_tsc  = 8'(merge16({8'h00, timestamp_control},
                                                          wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    // read data and acknowledge; unmapped reads return zero
    always_comb begin
        next_ack = bus_req;
        next_dat = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            unique case (idx)
                ccr_pkg::IDX_CTL0: next_dat = {24'h00_0000, clock_control_zero};
                ccr_pkg::IDX_CTL1: next_dat = {24'h00_0000, clock_control_one};
                ccr_pkg::IDX_CTL2: next_dat = {24'h00_0000, clock_control_two};
                ccr_pkg::IDX_POS:  next_dat = {8'h00, sysref_edge_position}; // R9
                ccr_pkg::IDX_FSA:  next_dat = {16'h0000, fullscale_range};
                ccr_pkg::IDX_TSC:  next_dat = {24'h00_0000, timestamp_control};
                default:           next_dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clock_control_zero <= ccr_pkg::RST_CTL0;
            clock_control_one  <= ccr_pkg::RST_CTL1;
            clock_control_two  <= ccr_pkg::RST_CTL2; // R6 R7 R8
            fullscale_range    <= ccr_pkg::RST_FSA;
            timestamp_control  <= ccr_pkg::RST_TSC;
            wb_ack_o           <= 1'b0;
            wb_dat_o           <= 32'h0000_0000;
        end else begin
            clock_control_zero <= next_ctl0;
            clock_control_one  <= next_ctl1;
            clock_control_two  <= next_ctl2;
            fullscale_range    <= next_fsa;
            timestamp_control  <= next_tsc;
            wb_ack_o           <= next_ack;
            wb_dat_o           <= next_dat;
        end
    end

    // field outputs straight from register bits
    assign device_clock_dc_pecl_en      = clock_control_one[ccr_pkg::CTL1_DEV_PECL]; // R4
    assign sysref_dc_pecl_en            = clock_control_one[ccr_pkg::CTL1_SR_PECL]; // R5
    assign clock_converter_gain_high    = clock_control_two[ccr_pkg::CTL2_GAIN]; // R6
    assign analog_supply_noise_suppress = clock_control_two[ccr_pkg::CTL2_NOISE]; // R7
    assign sample_clock_delay_sel       = clock_control_two[ccr_pkg::CTL2_DEL_LSB +: 2]; // R8
    assign sysref_delay_select          = clock_control_zero[ccr_pkg::CTL0_SEL_LSB +:
                                                             ccr_pkg::CTL0_SEL_W]; // R10
    assign sysref_window_fine           = clock_control_zero[ccr_pkg::CTL0_FINE]; // R11
    assign fullscale_range_chan_a       = fullscale_range;

    assign ts_active = clock_control_one[ccr_pkg::CTL1_TS_SR]
                     & timestamp_control[ccr_pkg::TSC_TS_EN] // R1
                     & timestamp_control[ccr_pkg::TSC_BYPASS]; // R2

    // sysref polarity and sample timestamp path
    always_comb begin
        next_sysref_aligned = sysref_sync ^ clock_control_one[ccr_pkg::CTL1_INVERT]; // R3
        next_sample_valid   = sample_in_valid;
        next_sample_out     = sample_in;
        if (ts_active) begin
            next_sample_out[0] = sysref_aligned; // R1
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sysref_aligned   <= 1'b0;
            sample_out       <= '0;
            sample_out_valid <= 1'b0;
            sysref_auto_cal  <= 1'b1;
        end else begin
            sysref_aligned   <= next_sysref_aligned;
            sample_out       <= next_sample_out;
            sample_out_valid <= next_sample_valid;
            sysref_auto_cal  <= (next_ctl0[ccr_pkg::CTL0_SEL_LSB +:
                                           ccr_pkg::CTL0_SEL_W] == 4'h0); // R10
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    chk_ack_follows: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse one cycle after request");
    chk_ts_lsb_sysref: assert property (ts_active && sample_in_valid // R1
        |=> sample_out[0] == $past(sysref_aligned) && sample_out_valid)
        else $error("timestamp lsb does not carry sysref");
    chk_ts_needs_bypass: assert property (!timestamp_control[ccr_pkg::TSC_BYPASS] // R2
        |=> sample_out == $past(sample_in))
        else $error("sample altered while down-converter active");
    chk_sysref_invert: assert property (clock_control_one[ccr_pkg::CTL1_INVERT] // R3
        && $stable(clock_control_one) |=> sysref_aligned == !$past(sysref_sync))
        else $error("inverted sysref not used for alignment");
    chk_devclk_pecl_wr: assert property (bus_wr && idx == ccr_pkg::IDX_CTL1 && wb_sel_i[0] // R4
        |=> device_clock_dc_pecl_en == $past(wb_dat_i[ccr_pkg::CTL1_DEV_PECL]))
        else $error("device clock pecl bit not written");
    chk_sysref_pecl_wr: assert property (bus_wr && idx == ccr_pkg::IDX_CTL1 && wb_sel_i[0] // R5
        |=> sysref_dc_pecl_en == $past(wb_dat_i[ccr_pkg::CTL1_SR_PECL]))
        else $error("sysref pecl bit not written");
    chk_reset_clock_two: assert property (!$past(rst_n) |-> clock_converter_gain_high // R6
        && !analog_supply_noise_suppress && sample_clock_delay_sel == 2'b01) // R7 R8
        else $error("clock control two reset value wrong");
    chk_pos_read_only: assert property (bus_wr && idx == ccr_pkg::IDX_POS && !pos_captured // R9
        |=> $stable(sysref_edge_position) || pos_captured)
        else $error("position status changed by a write");
    chk_fine_capture: assert property (pos_captured && $past(sysref_window_fine) // R11
        && $stable(taps_fine) |-> sysref_edge_position == taps_fine)
        else $error("fine taps not used when window fine set");
    chk_reserved_kept: assert property (bus_wr && idx == ccr_pkg::IDX_CTL2 && wb_sel_i[0] // R12
        |=> clock_control_two[7:5] == $past(wb_dat_i[7:5]))
        else $error("reserved bits not stored");

    // register field writes
    chk_gain_wr: assert property (bus_wr && idx == ccr_pkg::IDX_CTL2 && wb_sel_i[0] // R6
        |=> clock_converter_gain_high == $past(wb_dat_i[ccr_pkg::CTL2_GAIN]))
        else $error("gain bit not written");
    chk_noise_wr: assert property (bus_wr && idx == ccr_pkg::IDX_CTL2 && wb_sel_i[0] // R7
        |=> analog_supply_noise_suppress == $past(wb_dat_i[ccr_pkg::CTL2_NOISE]))
        else $error("noise suppress bit not written");
    chk_delay_sel_wr: assert property (bus_wr && idx == ccr_pkg::IDX_CTL2 && wb_sel_i[0] // R8
        |=> sample_clock_delay_sel == $past(wb_dat_i[ccr_pkg::CTL2_DEL_LSB +: 2]))
        else $error("sample clock delay not written");
    chk_reserved_ctl1: assert property (bus_wr && idx == ccr_pkg::IDX_CTL1 && wb_sel_i[0] // R12
        |=> clock_control_one[7:4] == $past(wb_dat_i[7:4]))
        else $error("clock control one reserved bits not stored");
    chk_fsa_wr: assert property (bus_wr && idx == ccr_pkg::IDX_FSA && wb_sel_i[1:0] == 2'b11
        |=> fullscale_range_chan_a == $past(wb_dat_i[15:0]))
        else $error("fullscale range not written");
    chk_window_fine_wr: assert property (bus_wr && idx == ccr_pkg::IDX_CTL0 && wb_sel_i[0] // R11
        |=> sysref_window_fine == $past(wb_dat_i[ccr_pkg::CTL0_FINE]))
        else $error("window fine bit not written");
    chk_pecl_held: assert property (!(bus_wr && idx == ccr_pkg::IDX_CTL1) // R4
        |=> $stable(device_clock_dc_pecl_en))
        else $error("device clock pecl bit changed without a write");

    // bus answer
    chk_ack_needs_req: assert property (wb_ack_o
        |-> $past(bus_req))
        else $error("ack without a request");
    chk_dat_idle_zero: assert property (!wb_ack_o
        |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    chk_lane_ignored: assert property (bus_wr && idx == ccr_pkg::IDX_FSA && !wb_sel_i[1]
        |=> $stable(fullscale_range_chan_a[15:8]))
        else $error("disabled byte lane written");

    // sysref, sample and position paths
    chk_aligned_plain: assert property (!clock_control_one[ccr_pkg::CTL1_INVERT] // R3
        && $stable(clock_control_one) |=> sysref_aligned == $past(sysref_sync))
        else $error("sysref altered while not inverted");
    chk_ts_needs_enable: assert property (!timestamp_control[ccr_pkg::TSC_TS_EN] // R1
        |=> sample_out == $past(sample_in))
        else $error("sample altered while timestamp disabled");
    chk_valid_follows: assert property (sample_in_valid
        |=> sample_out_valid)
        else $error("sample valid not passed on");
    chk_coarse_capture: assert property (pos_captured && !$past(sysref_window_fine) // R9
        && $stable(taps_coarse) |-> sysref_edge_position == taps_coarse)
        else $error("coarse taps not used when window fine clear");
    chk_pos_only_capture: assert property ($changed(sysref_edge_position) // R9
        |-> pos_captured)
        else $error("position changed without a capture");
    chk_pos_readback: assert property (bus_req && !wb_we_i && idx == ccr_pkg::IDX_POS // R9
        |=> wb_dat_o == {8'h00, $past(sysref_edge_position)})
        else $error("position read data wrong");
    chk_auto_cal_level: assert property (sysref_auto_cal // R10
        == (sysref_delay_select == 4'h0))
        else $error("auto calibration flag does not match delay select");

    cov_register_read: cover property (bus_req && !wb_we_i ##1 wb_ack_o);
    cov_ts_insert:     cover property (ts_active && sample_in_valid);
    cov_pos_capture:   cover property (pos_captured);
    cov_auto_cal:      cover property ($rose(sysref_auto_cal));
    cov_fine_capture:  cover property (pos_captured && sysref_window_fine);
endmodule

/* design/ccr_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module ccr_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // async in, synced out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_dout;

    always_comb begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stage1 <= '0;
            dout   <= '0;
        end else begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule
